// ---- logic/spt_timer_regs.vh ----
// constants of the self-polling timer unit
`ifndef SPT_TIMER_REGS_VH
`define SPT_TIMER_REGS_VH

// ----------------------------------------------------------------------
// reference prescaler
// ----------------------------------------------------------------------
`define SPT_PRESCALE_LAST 6'h3f

// ----------------------------------------------------------------------
// polling mode field encodings
// ----------------------------------------------------------------------
`define SPT_MODE_CONST 2'h0
`define SPT_MODE_FFB 2'h1
`define SPT_MODE_MIXED 2'h2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPT_RST_TIMER 16'h0000
`define SPT_RST_PERIOD 8'h00

`endif

// ---- logic/spt_timer.v ----
// self-polling timer unit: reference prescaler, on/off and period timers, scan control
//
// Functional notes
// - tick is fsys/64 divided by reference divider
// - on/off and period timers drive polling signal
// - mode field selects the polling behaviour
// - wake-up detection enters run mode while the receiver is on and enable is high
// - constant mode uses fixed on and off
// - A and B on, shared off, byte pairs
// - single config polls A, dual polls both
// - channel count per configuration from its setting
// - constant mode gives each channel full on time unless permanent search is on
// - one off window follows all on windows
// - wake-up time starts with start-up or hop
// - fast fall back drops channel on sync timeout
// - criterion failure moves on or sleeps
// - fast fall back times window with A only
// - early receiver stop leaves timer untouched
// - mixed mode: A constant, B fast fall back
// - permanent search wraps to A channel 1
// - active and idle factors skip periods
`include "spt_timer_regs.vh"

module spt_timer (
	input wire sys_clk_in,
	input wire reset_in,
	input wire poll_enable_in,
	input wire [1:0] poll_mode_in,
	input wire permanent_wakeup_search_enable_in,
	input wire dual_cfg_in,
	input wire [1:0] cfg_a_channels_in,
	input wire [1:0] cfg_b_channels_in,
	input wire [7:0] poll_ref_divider_in,
	input wire [7:0] cfg_a_on_time_low_in,
	input wire [7:0] cfg_a_on_time_high_in,
	input wire [7:0] cfg_b_on_time_low_in,
	input wire [7:0] cfg_b_on_time_high_in,
	input wire [7:0] poll_off_time_low_in,
	input wire [7:0] poll_off_time_high_in,
	input wire [7:0] active_period_factor_in,
	input wire [7:0] idle_period_factor_in,
	input wire wakeup_found_in,
	input wire bit_sync_in,
	input wire sync_timeout_in,
	input wire criterion_fail_in,
	input wire run_exit_in,
	output reg rx_on_out,
	output reg cfg_b_sel_out,
	output reg [1:0] channel_out,
	output reg first_channel_out,
	output reg run_mode_out,
	output reg idle_period_out
);

	// ------------------------------------------------------------------
	// reference prescaler
	// ------------------------------------------------------------------
	// pre_cnt divides by 64; ref_cnt applies the programmable divider
	reg [5:0] pre_cnt_reg;
	reg [7:0] ref_cnt_reg;
	reg tick_reg;
	wire [7:0] div_eff = (poll_ref_divider_in == 8'h00) ? 8'h01 : poll_ref_divider_in;
	wire pre_tick = (pre_cnt_reg == `SPT_PRESCALE_LAST);

	// divider of zero behaves as one so the tick never stops
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pre_cnt_reg <= 6'h00;
			ref_cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 6'h01;
			tick_reg <= 1'b0;
			if (pre_tick) begin
				if (ref_cnt_reg + 8'h01 >= div_eff) begin
					ref_cnt_reg <= 8'h00;
					tick_reg <= 1'b1;
				end else begin
					ref_cnt_reg <= ref_cnt_reg + 8'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// controller state codes
	// ------------------------------------------------------------------
	// stop holds everything off; run parks the scan after a wake-up
	localparam [1:0] ST_STOP = 2'h0;
	localparam [1:0] ST_ON = 2'h1;
	localparam [1:0] ST_OFF = 2'h2;
	localparam [1:0] ST_RUN = 2'h3;

	// ------------------------------------------------------------------
	// controller state
	// ------------------------------------------------------------------
	// scan position, receiver enable and start-up flag
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [15:0] tmr_reg;
	reg [15:0] tmr_next;
	reg cfg_b_reg;
	reg cfg_b_next;
	reg [1:0] ch_reg;
	reg [1:0] ch_next;
	reg rx_reg;
	reg rx_next;
	reg first_reg;
	reg first_next;
	// active/idle period bookkeeping
	reg idle_reg;
	reg idle_next;
	reg [7:0] per_cnt_reg;
	reg [7:0] per_cnt_next;

	// ------------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------------
	// durations are tick counts; a zero count expires on the first tick
	// a channel count of zero acts as one so the scan never stalls
	wire [15:0] on_a = {cfg_a_on_time_high_in, cfg_a_on_time_low_in};
	wire [15:0] on_b = {cfg_b_on_time_high_in, cfg_b_on_time_low_in};
	wire [15:0] off_t = {poll_off_time_high_in, poll_off_time_low_in};
	wire [1:0] n_a = (cfg_a_channels_in == 2'h0) ? 2'h1 : cfg_a_channels_in;
	wire [1:0] n_b = (cfg_b_channels_in == 2'h0) ? 2'h1 : cfg_b_channels_in;
	// active factor of zero acts as one; idle factor of zero disables idling
	wire [7:0] m_eff = (active_period_factor_in == 8'h00) ? 8'h01 : active_period_factor_in;
	// permanent search only takes effect in constant mode
	wire perm = permanent_wakeup_search_enable_in && (poll_mode_in == `SPT_MODE_CONST);

	// ------------------------------------------------------------------
	// scan position
	// ------------------------------------------------------------------
	// per-channel style reloads the timer per channel; the other style owns one window
	wire ffb_style = (poll_mode_in == `SPT_MODE_FFB) || perm ||
		((poll_mode_in == `SPT_MODE_MIXED) && cfg_b_reg);
	wire last_in_cfg = ({1'b0, ch_reg} + 3'h1) >= {1'b0, (cfg_b_reg ? n_b : n_a)};
	wire last = last_in_cfg && (cfg_b_reg || !dual_cfg_in);
	// window ends on the tick that finds one count left
	wire expire = tick_reg && (tmr_reg <= 16'h0001);
	// abort only while the receiver is really searching
	wire abort = ffb_style && rx_reg &&
		((!bit_sync_in && sync_timeout_in) || (bit_sync_in && criterion_fail_in));
	// advance within a configuration, then hop to B
	wire adv_b = last_in_cfg ? 1'b1 : cfg_b_reg;
	wire [1:0] adv_ch = last_in_cfg ? 2'h0 : (ch_reg + 2'h1);

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	// next-state logic of the scan controller
	// expiry outranks an abort in the same cycle, so a window never loses its tail
	always @* begin
		state_next = state_reg;
		tmr_next = (tick_reg && tmr_reg != 16'h0000) ? tmr_reg - 16'h0001 : tmr_reg;
		cfg_b_next = cfg_b_reg;
		ch_next = ch_reg;
		rx_next = rx_reg;
		first_next = first_reg;
		idle_next = idle_reg;
		per_cnt_next = per_cnt_reg;
		case (state_reg)
			ST_STOP: begin
				// every enable restarts from configuration A channel 1
				if (poll_enable_in) begin
					state_next = ST_ON;
					tmr_next = on_a;
					cfg_b_next = 1'b0;
					ch_next = 2'h0;
					rx_next = 1'b1;
					first_next = 1'b1;
					idle_next = 1'b0;
					per_cnt_next = `SPT_RST_PERIOD;
				end
			end
			ST_ON: begin
				if (wakeup_found_in && rx_reg && !idle_reg) begin
					state_next = ST_RUN;
					rx_next = 1'b0;
				end else if (expire) begin
					if (!ffb_style && !last) begin
						// next channel gets its own configuration's full on time
						cfg_b_next = adv_b;
						ch_next = adv_ch;
						tmr_next = adv_b ? on_b : on_a;
						first_next = 1'b0;
					end else begin
						state_next = ST_OFF;
						tmr_next = off_t;
						rx_next = 1'b0;
						first_next = 1'b0;
					end
				end else if (abort) begin
					// timer keeps running; only the receiver or channel changes
					first_next = 1'b0;
					if (!last) begin
						cfg_b_next = adv_b;
						ch_next = adv_ch;
					end else if (perm) begin
						cfg_b_next = 1'b0;
						ch_next = 2'h0;
					end else begin
						rx_next = 1'b0;
					end
				end
			end
			ST_OFF: begin
				// each master period restarts at configuration A channel 1
				if (expire) begin
					state_next = ST_ON;
					tmr_next = on_a;
					cfg_b_next = 1'b0;
					ch_next = 2'h0;
					rx_next = 1'b1;
					first_next = 1'b1;
					// active/idle period sequencing at each period boundary
					if (idle_reg) begin
						if (per_cnt_reg + 8'h01 >= idle_period_factor_in) begin
							idle_next = 1'b0;
							per_cnt_next = 8'h00;
						end else begin
							per_cnt_next = per_cnt_reg + 8'h01;
						end
					end else if (idle_period_factor_in != 8'h00) begin
						if (per_cnt_reg + 8'h01 >= m_eff) begin
							idle_next = 1'b1;
							per_cnt_next = 8'h00;
						end else begin
							per_cnt_next = per_cnt_reg + 8'h01;
						end
					end else begin
						per_cnt_next = 8'h00;
					end
				end
			end
			ST_RUN: begin
				// channel that woke up stays visible while in run mode
				if (run_exit_in) begin
					state_next = ST_ON;
					tmr_next = on_a;
					cfg_b_next = 1'b0;
					ch_next = 2'h0;
					rx_next = 1'b1;
					first_next = 1'b1;
					idle_next = 1'b0;
					per_cnt_next = 8'h00;
				end
			end
			default: begin
				state_next = ST_STOP;
			end
		endcase
		// a low enable wins over every other request
		if (!poll_enable_in) begin
			state_next = ST_STOP;
			rx_next = 1'b0;
			idle_next = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// state and output registers
	// ------------------------------------------------------------------
	// outputs follow the next values so they line up with the state registers
	always @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= ST_STOP;
			tmr_reg <= `SPT_RST_TIMER;
			cfg_b_reg <= 1'b0;
			ch_reg <= 2'h0;
			rx_reg <= 1'b0;
			first_reg <= 1'b0;
			idle_reg <= 1'b0;
			per_cnt_reg <= `SPT_RST_PERIOD;
			rx_on_out <= 1'b0;
			cfg_b_sel_out <= 1'b0;
			channel_out <= 2'h0;
			first_channel_out <= 1'b0;
			run_mode_out <= 1'b0;
			idle_period_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			cfg_b_reg <= cfg_b_next;
			ch_reg <= ch_next;
			rx_reg <= rx_next;
			first_reg <= first_next;
			idle_reg <= idle_next;
			per_cnt_reg <= per_cnt_next;
			// idle periods keep the receiver dark but run the same timing
			rx_on_out <= (state_next == ST_ON) && rx_next && !idle_next;
			cfg_b_sel_out <= cfg_b_next;
			channel_out <= ch_next;
			// start-up flag only for a period that really powers the receiver
			first_channel_out <= first_next && !idle_next && (state_next == ST_ON);
			run_mode_out <= (state_next == ST_RUN);
			idle_period_out <= idle_next;
		end
	end

endmodule

// ---- testbench/spt_timer_props.sv ----
// port checker of the self-polling timer unit
module spt_timer_props (
	input wire sys_clk_in,
	input wire reset_in,
	input wire poll_enable_in,
	input wire dual_cfg_in,
	input wire [1:0] cfg_a_channels_in,
	input wire wakeup_found_in,
	input wire run_exit_in,
	input wire rx_on_out,
	input wire cfg_b_sel_out,
	input wire [1:0] channel_out,
	input wire first_channel_out,
	input wire run_mode_out,
	input wire idle_period_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// polling relations
	// ----
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// receiver on at config A channel 1
	sequence s_on_a0;
		rx_on_out && channel_out == 2'h0 && !cfg_b_sel_out;
	endsequence
	sequence s_wake;
		poll_enable_in && rx_on_out && wakeup_found_in && !run_mode_out;
	endsequence
	AST_START: assert property ($rose(poll_enable_in) |=> s_on_a0 ##0 first_channel_out)
		else $error("polling start wrong");
	AST_WAKE: assert property (s_wake |=> run_mode_out && !rx_on_out)
		else $error("wake not taken");
	AST_RUN_OFF: assert property (run_mode_out |-> !rx_on_out)
		else $error("receiver on in run mode");
	AST_EXIT: assert property (poll_enable_in && run_mode_out && run_exit_in |=> s_on_a0 ##0 !run_mode_out)
		else $error("run exit wrong");
	AST_STOP: assert property (!poll_enable_in |=> !rx_on_out && !run_mode_out)
		else $error("disabled unit still active");
	AST_SINGLE: assert property (poll_enable_in && rx_on_out && !dual_cfg_in |-> !cfg_b_sel_out)
		else $error("config B polled in single mode");
	AST_CHAN_A: assert property (poll_enable_in && rx_on_out && !cfg_b_sel_out |->
		channel_out <= ((cfg_a_channels_in == 2'h0) ? 2'h0 : cfg_a_channels_in - 2'h1))
		else $error("channel beyond count");
	AST_IDLE: assert property (idle_period_out |-> !rx_on_out)
		else $error("receiver on in idle period");
	AST_FIRST: assert property (first_channel_out |-> s_on_a0)
		else $error("first channel flag wrong");
endmodule

// ---- testbench/spt_front_end.sv ----
// behavioural receiver front end facing the timer unit
module spt_front_end (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic rx_on_in,
	input wire logic cfg_b_in,
	input wire logic [1:0] channel_in,
	input wire logic sync_mode_in,
	input wire logic wake_cmd_in,
	output logic bit_sync_out,
	output logic sync_timeout_out,
	output logic criterion_fail_out,
	output logic wakeup_found_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] wait_reg;
	logic [2:0] chan_reg;
	// each search ends 20 clocks after a hop, far inside the bench on windows
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_reg <= 5'h00;
			chan_reg <= 3'h0;
		end else begin
			chan_reg <= {cfg_b_in, channel_in};
			if (!rx_on_in || {cfg_b_in, channel_in} != chan_reg)
				wait_reg <= 5'h14;
			else if (wait_reg != 5'h00)
				wait_reg <= wait_reg - 5'h01;
		end
	end
	// verdicts only while powered, so a sleeping receiver reports nothing
	assign bit_sync_out = rx_on_in & sync_mode_in;
	assign sync_timeout_out = rx_on_in & ~sync_mode_in & (wait_reg == 5'h01);
	assign criterion_fail_out = rx_on_in & sync_mode_in & (wait_reg == 5'h01);
	assign wakeup_found_out = rx_on_in & wake_cmd_in;
endmodule

// ---- testbench/tb_top.sv ----
// top testbench of the self-polling timer unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0, reset_in = 1'b1, poll_enable_in = 1'b0, run_exit_in = 1'b0;
	logic permanent_wakeup_search_enable_in = 1'b0, dual_cfg_in = 1'b0;
	logic [1:0] poll_mode_in = 2'h0, cfg_a_channels_in = 2'h2, cfg_b_channels_in = 2'h1;
	logic [7:0] poll_ref_divider_in = 8'h01, cfg_a_on_time_low_in = 8'h02;
	logic [7:0] cfg_a_on_time_high_in = 8'h00, cfg_b_on_time_low_in = 8'h03;
	logic [7:0] cfg_b_on_time_high_in = 8'h00, poll_off_time_low_in = 8'h04;
	logic [7:0] poll_off_time_high_in = 8'h00, active_period_factor_in = 8'h01;
	logic [7:0] idle_period_factor_in = 8'h00;
	logic wakeup_found_in, bit_sync_in, sync_timeout_in, criterion_fail_in;
	logic sync_mode = 1'b0, wake_cmd = 1'b0;
	logic rx_on_out, cfg_b_sel_out, first_channel_out, run_mode_out, idle_period_out;
	logic [1:0] channel_out;
	int n_fail = 0, total_checks = 0;
	always #4 sys_clk_in = ~sys_clk_in;
	spt_timer uut (.*);
	spt_front_end fe (.clk_in(sys_clk_in), .rst_in(reset_in), .rx_on_in(rx_on_out),
		.cfg_b_in(cfg_b_sel_out), .channel_in(channel_out), .sync_mode_in(sync_mode),
		.wake_cmd_in(wake_cmd), .bit_sync_out(bit_sync_in), .sync_timeout_out(sync_timeout_in),
		.criterion_fail_out(criterion_fail_in), .wakeup_found_out(wakeup_found_in));
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [15:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// stop first so every setting lands on an idle unit
	task automatic setup(input logic [1:0] md, input logic pm, dl, input logic [1:0] an, bn,
		input logic [7:0] dv, idl);
		@(posedge sys_clk_in);
		poll_enable_in <= 1'b0;
		poll_mode_in <= md;
		permanent_wakeup_search_enable_in <= pm;
		dual_cfg_in <= dl;
		cfg_a_channels_in <= an;
		cfg_b_channels_in <= bn;
		poll_ref_divider_in <= dv;
		idle_period_factor_in <= idl;
		@(posedge sys_clk_in);
		poll_enable_in <= 1'b1;
	endtask
	// first window starts mid tick, so the second period is the one timed
	task automatic meas(input logic [15:0] ticks, hops);
		int n, h;
		logic pf;
		logic [2:0] p;
		repeat (2) begin
			while (first_channel_out !== 1'b0) @(posedge sys_clk_in);
			while (first_channel_out !== 1'b1) @(posedge sys_clk_in);
		end
		{n, h, pf, p} = {32'h0, 32'h0, 1'b1, 3'h0};
		while (1) begin
			@(posedge sys_clk_in);
			n++;
			if (first_channel_out === 1'b1 && !pf) break;
			pf = first_channel_out;
			if (rx_on_out === 1'b1 && {cfg_b_sel_out, channel_out} !== p) h++;
			p = {cfg_b_sel_out, channel_out};
		end
		chk("period", ticks * 16'h0040 * poll_ref_divider_in, n[15:0]);
		if (hops == 16'h0)
			chk("wrap", 16'h1, {15'h0, h > 2});
		else
			chk("hops", hops, h[15:0]);
	endtask
	// ----
	// tests
	// ----
	initial begin
		repeat (8) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		setup(2'h0, 1'b0, 1'b1, 2'h2, 2'h1, 8'h01, 8'h00);
		meas(16'h000b, 16'h0002);
		setup(2'h0, 1'b0, 1'b0, 2'h2, 2'h1, 8'h02, 8'h00);
		meas(16'h0008, 16'h0001);
		for (int s = 0; s < 2; s++) begin
			sync_mode <= s[0];
			setup(2'h1, 1'b0, 1'b1, 2'h2, 2'h1, 8'h01, 8'h00);
			meas(16'h0006, 16'h0002);
		end
		sync_mode <= 1'b0;
		setup(2'h2, 1'b0, 1'b1, 2'h2, 2'h2, 8'h01, 8'h00);
		meas(16'h000b, 16'h0003);
		setup(2'h0, 1'b1, 1'b0, 2'h2, 2'h1, 8'h01, 8'h00);
		meas(16'h0006, 16'h0000);
		// two active periods then one idle, so the active factor matters
		active_period_factor_in <= 8'h02;
		setup(2'h0, 1'b0, 1'b0, 2'h2, 2'h1, 8'h01, 8'h01);
		meas(16'h0010, 16'h0001);
		repeat (600) @(posedge sys_clk_in);
		chk("active", 16'h0003, {13'h0, idle_period_out, rx_on_out, first_channel_out});
		repeat (512) @(posedge sys_clk_in);
		chk("idle", 16'h0004, {13'h0, idle_period_out, rx_on_out, first_channel_out});
		setup(2'h0, 1'b0, 1'b0, 2'h2, 2'h1, 8'h01, 8'h00);
		// skip the stale sample from before the stop took effect
		@(posedge sys_clk_in);
		while (rx_on_out !== 1'b1) @(posedge sys_clk_in);
		wake_cmd <= 1'b1;
		@(posedge sys_clk_in);
		wake_cmd <= 1'b0;
		@(posedge sys_clk_in);
		chk("run", 16'h2, {14'h0, run_mode_out, rx_on_out});
		run_exit_in <= 1'b1;
		@(posedge sys_clk_in);
		run_exit_in <= 1'b0;
		@(posedge sys_clk_in);
		chk("exit", 16'h1, {14'h0, run_mode_out, rx_on_out});
		poll_off_time_high_in <= 8'h01;
		poll_off_time_low_in <= 8'h00;
		setup(2'h0, 1'b0, 1'b0, 2'h3, 2'h1, 8'h01, 8'h00);
		meas(16'h0106, 16'h0002);
		end_sim;
	end
	// watchdog sized above the longest expected run
	initial begin
		repeat (80000) @(posedge sys_clk_in);
		n_fail++;
		end_sim;
	end
endmodule

bind spt_timer spt_timer_props chk_i (.*);
